// file: dv/eefl_host_model.sv
/*
  Host model: enables, bit-field clears, PHY flag reads, cancels.
  Assumes tasks are entered just after a falling clock edge.
*/
`timescale 1ns/1ps
module eefl_host_model (
  // Clock
  input  wire logic              i_core_clk,
  // Host controls
  output eefl_pkg::eefl_enable_t o_enable,
  output logic [7:0]             o_flag_clr,
  output logic                   o_phy_flags_rd,
  output logic [15:0]            o_phy_enable_wdata,
  output logic                   o_phy_enable_we,
  output logic                   o_tx_cancel,
  output logic                   o_abort_clr
);
  import eefl_pkg::*;
  // **********
  // Idle levels
  // **********
  initial begin
    o_enable = '0;
    o_flag_clr = 8'h00;
    o_phy_flags_rd = 1'b0;
    o_phy_enable_wdata = 16'h0000;
    o_phy_enable_we = 1'b0;
    o_tx_cancel = 1'b0;
    o_abort_clr = 1'b0;
  end
  // Enables are levels, no strobe needed
  task automatic set_en(input eefl_enable_t e);
    o_enable = e;
  endtask : set_en
  task automatic bfc(input logic [7:0] m);
    o_flag_clr = m;
    @(negedge i_core_clk);
    o_flag_clr = 8'h00;
  endtask : bfc
  task automatic phy_read();
    o_phy_flags_rd = 1'b1;
    @(negedge i_core_clk);
    o_phy_flags_rd = 1'b0;
  endtask : phy_read
  task automatic phy_en_write(input logic [15:0] v);
    o_phy_enable_wdata = v & 16'h0012;
    o_phy_enable_we = 1'b1;
    @(negedge i_core_clk);
    o_phy_enable_we = 1'b0;
  endtask : phy_en_write
  task automatic cancel();
    o_tx_cancel = 1'b1;
    @(negedge i_core_clk);
    o_tx_cancel = 1'b0;
  endtask : cancel
  task automatic ab_clr();
    o_abort_clr = 1'b1;
    @(negedge i_core_clk);
    o_abort_clr = 1'b0;
  endtask : ab_clr
endmodule : eefl_host_model

// file: dv/ethernet_event_flag_logic_bench.sv
/*
  Bench for the event flag logic: one task per flag source.
  Assumes the host model owns enables, clears and PHY reads.
*/
`timescale 1ns/1ps
module ethernet_event_flag_logic_bench;
  import eefl_pkg::*;
  logic             clk;
  logic             rst;
  eefl_enable_t     en;
  logic [7:0]       clr, flg, pkt_cnt;
  logic [15:0]      wd, pfl, pen;
  logic             rd, we, cancel, ab_clr, req, abrt, vec_we, disc, irq_n;
  logic             rx_act, buf_full, store, fdx;
  logic             req_set, done_ok, link;
  eefl_abort_t      cause;
  int               vec_cnt = 0, disc_cnt = 0, cycles = 0, fails = 0, compares = 0;

  always #20 clk = ~clk;

  eefl_host_model host (.i_core_clk(clk), .o_enable(en), .o_flag_clr(clr),
    .o_phy_flags_rd(rd), .o_phy_enable_wdata(wd), .o_phy_enable_we(we),
    .o_tx_cancel(cancel), .o_abort_clr(ab_clr));

  eefl_event_flags uut (.i_core_clk(clk), .i_rst(rst), .i_enable(en),
    .i_phy_enable_wdata(wd), .i_phy_enable_we(we), .i_flag_clr(clr),
    .i_phy_flags_rd(rd), .i_rx_active(rx_act), .i_rx_buf_full(buf_full),
    .i_received_packet_counter(pkt_cnt), .i_rx_store(store), .i_full_duplex(fdx),
    .i_abort_cause(cause), .i_transmit_request_set(req_set),
    .i_transmit_request_host_clr(cancel), .i_transmit_done_ok(done_ok),
    .i_abort_status_clr(ab_clr), .i_live_link_state(link),
    .o_event_flag_reg(flg), .o_phy_event_flags(pfl), .o_phy_event_enable_reg(pen),
    .o_transmit_request(req), .o_transmit_abort_status(abrt),
    .o_status_vector_we(vec_we), .o_rx_discard(disc), .o_irq_n(irq_n));

  // **********
  // Pulse counters and hang guard
  // **********
  // Pulses are counted so their exact cycle does not matter
  always @(posedge clk) begin
    cycles++;
    if (vec_we === 1'b1) vec_cnt++;
    if (disc === 1'b1) disc_cnt++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic ck(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : ck

  task automatic ck_f(input logic [7:0] e);
    ck("flags", {8'h00, flg}, {8'h00, e});
  endtask : ck_f

  task automatic ck_i(input logic e);
    ck("irq_n", 16'(irq_n), 16'(e));
  endtask : ck_i

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // **********
  // Scenarios
  // **********
  task automatic t_reset();
    ck_f(8'h00);
    ck("phy", pfl, 16'h0000);
    ck("phy_en", pen, 16'h0000);
    ck("req", 16'(req), 16'h0000);
    ck_i(1'b1);
  endtask : t_reset

  // Overflow, then count at 255, then 254 which must not abort
  task automatic t_rx_err();
    int d0;
    host.set_en(5'b11000);
    rx_act = 1'b1;
    buf_full = 1'b1;
    d0 = disc_cnt;
    store = 1'b1;
    tick(1);
    store = 1'b0;
    tick(3);
    ck("discard", 16'(disc_cnt - d0), 16'h1);
    ck_f(8'h01);
    ck_i(1'b0);
    buf_full = 1'b0;
    tick(20);
    ck_f(8'h01);
    host.set_en(5'b01000);
    tick(3);
    ck_i(1'b1);
    host.bfc(8'h01);
    tick(3);
    ck_f(8'h00);
    for (int k = 0; k < 2; k++) begin
      pkt_cnt = k ? 8'hfe : 8'hff;
      store = 1'b1;
      tick(1);
      store = 1'b0;
      tick(3);
      ck_f(k ? 8'h00 : 8'h01);
      host.bfc(8'h01);
      tick(2);
    end
    rx_act = 1'b0;
  endtask : t_rx_err

  // Every abort cause, half and full duplex
  task automatic t_tx_abort();
    logic hit;
    int   v0;
    host.set_en(5'b10100);
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 5; i++) begin
        fdx = d[0];
        hit = (d == 0) || (i == 0);
        req_set = 1'b1;
        tick(1);
        req_set = 1'b0;
        tick(2);
        ck("req", 16'(req), 16'h1);
        v0 = vec_cnt;
        cause = 5'(1 << i);
        tick(1);
        cause = '0;
        tick(3);
        ck_f(hit ? 8'h0a : 8'h00);
        ck("req", 16'(req), 16'(!hit));
        ck("abort", 16'(abrt), 16'(hit));
        ck("vector", 16'(vec_cnt - v0), 16'(hit));
        ck_i(!hit);
        if (!hit) begin
          host.cancel();
          tick(3);
          ck_f(8'h08);
        end
        host.ab_clr();
        host.bfc(8'h0a);
        tick(3);
        ck_f(8'h00);
        ck("abort", 16'(abrt), 16'h0);
        ck_i(1'b1);
      end
    end
    fdx = 1'b0;
  endtask : t_tx_abort

  task automatic t_tx_done();
    host.set_en(5'b10010);
    req_set = 1'b1;
    tick(1);
    req_set = 1'b0;
    tick(2);
    done_ok = 1'b1;
    tick(1);
    done_ok = 1'b0;
    tick(3);
    ck("req", 16'(req), 16'h0);
    ck_f(8'h08);
    ck_i(1'b0);
    host.set_en(5'b00010);
    tick(3);
    ck_i(1'b1);
    host.bfc(8'h08);
    tick(3);
    ck_f(8'h00);
  endtask : t_tx_done

  // Link change before and after the PHY enables
  task automatic t_link();
    host.set_en(5'b10001);
    link = 1'b1;
    tick(6);
    ck("phy", pfl, 16'h0010);
    ck_f(8'h00);
    ck_i(1'b1);
    host.phy_read();
    tick(3);
    ck("phy", pfl, 16'h0000);
    host.phy_en_write(16'h0012);
    tick(2);
    ck("phy_en", pen, 16'h0012);
    link = 1'b0;
    tick(6);
    ck("phy", pfl, 16'h0014);
    ck_f(8'h10);
    ck_i(1'b0);
    host.bfc(8'h10);
    host.set_en(5'b10000);
    tick(3);
    ck_f(8'h10);
    ck_i(1'b1);
    host.phy_read();
    tick(3);
    ck("phy", pfl, 16'h0000);
    ck_f(8'h00);
  endtask : t_link

  // Stimulus levels are set here, so every driven input stays a real stimulus
  initial begin
    clk      = 1'b0;
    rst      = 1'b1;
    pkt_cnt  = 8'h00;
    rx_act   = 1'b0;
    buf_full = 1'b0;
    store    = 1'b0;
    fdx      = 1'b0;
    req_set  = 1'b0;
    done_ok  = 1'b0;
    link     = 1'b0;
    cause    = '0;
    tick(5);
    rst = 1'b0;
    tick(1);
    t_reset();
    t_rx_err();
    t_tx_abort();
    t_tx_done();
    t_link();
    wrap_up();
  end
endmodule : ethernet_event_flag_logic_bench

// file: logic/eefl_event_flags.sv
/*
  Ethernet event flag logic: receive error, transmit error, transmit done and
  link change flags, their enables, the PHY flag register with clear on read,
  and the active-low interrupt pin.
  Assumes the SPI command decoder and management read logic sit outside and
  deliver single-cycle strobes on i_core_clk; the live link state is a pin.
*/
// Operation
// RL1 - PHY link flag set on change, read clears
// RL2 - PHY global flag for enabled events, read clears
// RL3 - Host keeps reserved bits; zeros read back
// RL4 - Overflow or count 255 aborts, sets receive error
// RL5 - Receive error held until host clear
// RL6 - Receive error drives pin with both enables
// RL7 - Host services packets then clears receive error
// RL8 - Transmit abort causes set transmit error flag
// RL9 - Transmit error held; one-cycle pin pulse (pin here stays low while flag and both enables are set)
// RL10 - Abort clears request, sets abort status, status vector
// RL11 - Host clears late collision and abort status
// RL12 - Full duplex: only oversize frame raises error
// RL13 - Transmit error also sets transmit done
// RL14 - Request falling edge sets transmit done
// RL15 - Host judges success from done and abort
// RL16 - Transmit done held; pin with both enables
// RL17 - Link flag mirrors PHY global flag when enabled
// RL18 - PHY global equals PHY link when enabled
// RL19 - Link interrupt needs all four enables
// RL20 - PHY register read clears all link flags
// RL21 - Host may poll link flag instead
// RL22 - Main flag register bit layout
// RL23 - PHY enable register bits 4 and 1
// RL24 - Pin is OR of enabled flags, gated
`timescale 1ns/1ps
module eefl_event_flags #(
  parameter int unsigned PKT_CNT_W = 8
) (
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst,
  // Enables written by the host
  input  wire eefl_pkg::eefl_enable_t i_enable,
  input  wire logic [15:0]        i_phy_enable_wdata,
  input  wire logic               i_phy_enable_we,
  // Host clear strobes (bit-field clear of the main flag register)
  input  wire logic [7:0]         i_flag_clr,
  // PHY flag register management read strobe
  input  wire logic               i_phy_flags_rd,
  // Receive path events
  input  wire logic               i_rx_active,
  input  wire logic               i_rx_buf_full,
  input  wire logic [PKT_CNT_W-1:0] i_received_packet_counter,
  input  wire logic               i_rx_store,
  // Transmit path events
  input  wire logic               i_full_duplex,
  input  wire eefl_pkg::eefl_abort_t i_abort_cause,
  input  wire logic               i_transmit_request_set,
  input  wire logic               i_transmit_request_host_clr,
  input  wire logic               i_transmit_done_ok,
  input  wire logic               i_abort_status_clr,
  // Link state from the PHY pin
  input  wire logic               i_live_link_state,
  // Outputs
  output logic [7:0]              o_event_flag_reg,
  output logic [15:0]             o_phy_event_flags,
  output logic [15:0]             o_phy_event_enable_reg,
  output logic                    o_transmit_request,
  output logic                    o_transmit_abort_status,
  output logic                    o_status_vector_we,
  output logic                    o_rx_discard,
  output logic                    o_irq_n
);
  import eefl_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (PKT_CNT_W < 8) begin : g_bad_width
    $error("PKT_CNT_W must hold the count 255");
  end

  localparam logic [PKT_CNT_W-1:0] CNT_SAT = PKT_CNT_W'(PKT_CNT_MAX);

  // ****************************************************************
  // Link pin synchroniser: three stages, change when 2 and 3 agree
  // ****************************************************************
  logic [2:0] link_sync_d, link_sync_q;
  logic       link_stable_d, link_stable_q;

  always_comb begin
    link_sync_d   = {link_sync_q[1:0], i_live_link_state};
    link_stable_d = link_stable_q;
    if (link_sync_q[1] == link_sync_q[2]) begin
      link_stable_d = link_sync_q[2];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      link_sync_q   <= 3'b000;
      link_stable_q <= 1'b0;
    end else begin
      link_sync_q   <= link_sync_d;
      link_stable_q <= link_stable_d;
    end
  end

  logic link_change;
  assign link_change = link_stable_d != link_stable_q;

  // ****************************************************************
  // PHY enable and PHY flag register
  // ****************************************************************
  logic [15:0] phy_en_d, phy_en_q;
  logic        plnk_d, plnk_q, pglb_d, pglb_q;
  logic        phy_both_en;

  assign phy_both_en = phy_en_q[PHY_EN_LINK] & phy_en_q[PHY_EN_GLB];

  always_comb begin
    phy_en_d = phy_en_q;
    // RL23 enable bit layout
    if (i_phy_enable_we) begin
      phy_en_d = 16'h0000;
      phy_en_d[PHY_EN_LINK] = i_phy_enable_wdata[PHY_EN_LINK];
      phy_en_d[PHY_EN_GLB]  = i_phy_enable_wdata[PHY_EN_GLB];
    end
    plnk_d = plnk_q;
    pglb_d = pglb_q;
    // RL20 read clears flags
    if (i_phy_flags_rd) begin
      plnk_d = 1'b0;
      pglb_d = 1'b0;
    end
    // RL1 change sets link flag; set wins over read
    if (link_change) begin
      plnk_d = 1'b1;
    end
    // RL2 global flag for enabled source
    // RL18 single PHY source
    if (link_change && phy_en_q[PHY_EN_LINK]) begin
      pglb_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phy_en_q <= PHY_EN_RESET;
      plnk_q   <= 1'b0;
      pglb_q   <= 1'b0;
    end else begin
      phy_en_q <= phy_en_d;
      plnk_q   <= plnk_d;
      pglb_q   <= pglb_d;
    end
  end

  // ****************************************************************
  // Receive error detection
  // ****************************************************************
  logic rx_abort;
  // RL4 overflow or saturated counter
  assign rx_abort = i_rx_active & i_rx_store &
                    (i_rx_buf_full | (i_received_packet_counter == CNT_SAT));

  // ****************************************************************
  // Transmit request, abort status and done detection
  // ****************************************************************
  logic req_d, req_q, abrt_d, abrt_q, vec_d, vec_q;
  logic tx_abort;

  // RL8 any abort cause
  // RL12 full duplex: only oversize frame
  assign tx_abort = req_q & (i_full_duplex ? i_abort_cause.oversize_frame : (|i_abort_cause));

  always_comb begin
    req_d  = req_q;
    abrt_d = abrt_q;
    vec_d  = 1'b0;
    if (i_transmit_request_set) begin
      req_d = 1'b1;
    end
    if (i_transmit_request_host_clr || i_transmit_done_ok) begin
      req_d = 1'b0;
    end
    if (i_abort_status_clr) begin
      abrt_d = 1'b0;
    end
    // RL10 abort ends request, flags status, writes vector
    if (tx_abort) begin
      req_d  = 1'b0;
      abrt_d = 1'b1;
      vec_d  = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      req_q  <= 1'b0;
      abrt_q <= 1'b0;
      vec_q  <= 1'b0;
    end else begin
      req_q  <= req_d;
      abrt_q <= abrt_d;
      vec_q  <= vec_d;
    end
  end

  logic req_fall;
  // RL14 falling request sets done
  assign req_fall = req_q & ~req_d;

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  logic rxerr_flag, txerr_flag, txdone_flag, link_flag;

  // RL5 held until host clear
  eefl_sticky_flag u_rxerr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (rx_abort),
    .i_clr      (i_flag_clr[FLG_RX_ERR]),
    .o_flag     (rxerr_flag)
  );

  // RL9 held until host clear
  eefl_sticky_flag u_txerr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (tx_abort),
    .i_clr      (i_flag_clr[FLG_TX_ERR]),
    .o_flag     (txerr_flag)
  );

  // RL13 abort drops request, so done sets together
  // RL16 held until host clear
  eefl_sticky_flag u_txdone (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (req_fall),
    .i_clr      (i_flag_clr[FLG_TX_DONE]),
    .o_flag     (txdone_flag)
  );

  // Link flag is read-only: only the PHY read clears it
  logic link_d, link_q;
  always_comb begin
    link_d = link_q;
    if (i_phy_flags_rd) begin
      link_d = 1'b0;
    end
    // RL17 mirror PHY global when both enabled
    if (phy_both_en && pglb_d) begin
      link_d = 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_d;
    end
  end
  assign link_flag = link_q;

  // ****************************************************************
  // Interrupt pin and register outputs
  // ****************************************************************
  logic       irq_d;
  logic       irq_n_q;
  logic [7:0] eflg_d;
  logic [15:0] pflg_d;

  always_comb begin
    // RL24 OR of enabled flags gated globally
    // RL6 receive error source
    // RL16 transmit done source
    // RL19 link needs four enables
    irq_d = i_enable.global_irq_enable &
            ((rxerr_flag  & i_enable.receive_error_enable) |
             (txerr_flag  & i_enable.transmit_error_enable) |
             (txdone_flag & i_enable.transmit_done_enable) |
             (link_flag   & i_enable.link_change_enable & phy_both_en));
    // RL22 main flag layout, bit 2 reserved as zero
    eflg_d = FLG_RESET;
    eflg_d[FLG_RX_ERR]  = rxerr_flag;
    eflg_d[FLG_TX_ERR]  = txerr_flag;
    eflg_d[FLG_TX_DONE] = txdone_flag;
    eflg_d[FLG_LINK]    = link_flag;
    // RL3 bits 5, 3, 0 read zero
    pflg_d = PHY_RSVD_RESET;
    pflg_d[PHY_FLG_LINK] = plnk_q;
    pflg_d[PHY_FLG_GLB]  = pglb_q;
  end

  logic [7:0]  eflg_q;
  logic [15:0] pflg_q;
  logic        rxd_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_n_q <= 1'b1;
      eflg_q  <= FLG_RESET;
      pflg_q  <= PHY_RSVD_RESET;
      rxd_q   <= 1'b0;
    end else begin
      irq_n_q <= ~irq_d;
      eflg_q  <= eflg_d;
      pflg_q  <= pflg_d;
      rxd_q   <= rx_abort;
    end
  end

  assign o_irq_n                 = irq_n_q;
  assign o_event_flag_reg        = eflg_q;
  assign o_phy_event_flags       = pflg_q;
  assign o_phy_event_enable_reg  = phy_en_q;
  assign o_transmit_request      = req_q;
  assign o_transmit_abort_status = abrt_q;
  assign o_status_vector_we      = vec_q;
  assign o_rx_discard            = rxd_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RXERR_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rx_abort |=> rxerr_flag ##1 eflg_q[FLG_RX_ERR]) // RL4
    else $error("receive error not reported");
  AST_RXERR_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rxerr_flag && !i_flag_clr[FLG_RX_ERR] |=> rxerr_flag) // RL5
    else $error("receive error dropped without clear");
  AST_TXERR_DONE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(txerr_flag) |-> $rose(txdone_flag) || $past(txdone_flag)) // RL13
    else $error("transmit done not set with error");
  AST_REQ_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(req_q) |-> txdone_flag) // RL14
    else $error("request fall without done");
  AST_ABORT_STAT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    tx_abort |=> !req_q && abrt_q && vec_q) // RL10
    else $error("abort side effects missing");
  AST_FD_ONLY5: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_full_duplex && !i_abort_cause.oversize_frame |-> !tx_abort) // RL12
    else $error("collision abort in full duplex");
  AST_PHY_RD_CLR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_phy_flags_rd && !link_change |=> !plnk_q && !pglb_q && !link_q) // RL20
    else $error("PHY read did not clear flags");
  AST_LINK_MIRROR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    phy_both_en && $stable(phy_en_q) |-> link_q == pglb_q && pglb_q == plnk_q) // RL18
    else $error("link flags disagree");
  AST_LINK_DEFAULT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !phy_both_en && !$past(phy_both_en) && !$past(link_q) |-> !link_q) // RL17
    else $error("link flag set while disabled");
  AST_IRQ_PIN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    irq_d |=> !o_irq_n) // RL24
    else $error("interrupt pin not asserted");
  AST_IRQ_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_enable.global_irq_enable |=> o_irq_n) // RL6
    else $error("pin asserted without global enable");

  COV_RXERR: cover property (@(posedge i_core_clk) rx_abort);
  COV_ABORT: cover property (@(posedge i_core_clk) tx_abort ##1 txdone_flag);
  COV_LINK:  cover property (@(posedge i_core_clk) $rose(link_q) ##[1:4] i_phy_flags_rd);

endmodule : eefl_event_flags

// file: logic/eefl_pkg.sv
/*
  Package for the Ethernet event flag logic: flag and enable bit positions,
  PHY flag register layout, reset values, timing figures and carrier structs.
  Assumes a single core clock domain at 25 MHz.
*/
package eefl_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 40000;
  // Deferral limit in nanoseconds, as printed (2.4287 ms)
  localparam int unsigned UNLIMITED_WAIT_ENABLE_LIMIT_NS  = 2428700;
  // Longest time: round down to whole cycles
  localparam int unsigned UNLIMITED_WAIT_ENABLE_LIMIT_CYC = (UNLIMITED_WAIT_ENABLE_LIMIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LATE_COL_BYTES  = 64;
  localparam int unsigned PKT_CNT_MAX     = 255;

  // ****************************************************************
  // Main flag register bit positions
  // ****************************************************************
  localparam int unsigned FLG_RX_ERR   = 0;
  localparam int unsigned FLG_TX_ERR   = 1;
  localparam int unsigned FLG_TX_DONE  = 3;
  localparam int unsigned FLG_LINK     = 4;
  localparam int unsigned FLG_COPY     = 5;
  localparam int unsigned FLG_PKT      = 6;
  localparam logic [7:0]  FLG_RESET    = 8'h00;

  // ****************************************************************
  // PHY flag and enable register layout
  // ****************************************************************
  localparam int unsigned PHY_FLG_LINK = 4;
  localparam int unsigned PHY_FLG_GLB  = 2;
  localparam int unsigned PHY_EN_LINK  = 4;
  localparam int unsigned PHY_EN_GLB   = 1;
  localparam logic [15:0] PHY_EN_RESET = 16'h0000;
  // Reserved bits 15..6 and 1 always read back as zero, from reset onwards
  localparam logic [15:0] PHY_RSVD_MASK = 16'hffc2;
  localparam logic [15:0] PHY_RSVD_RESET = 16'h0000;

  // ****************************************************************
  // Carrier structs
  // ****************************************************************
  // Main enable register contents
  typedef struct packed {
    logic global_irq_enable;
    logic receive_error_enable;
    logic transmit_error_enable;
    logic transmit_done_enable;
    logic link_change_enable;
  } eefl_enable_t;

  // Transmit abort causes
  typedef struct packed {
    logic excess_collisions;
    logic late_collision;
    logic collision_after_64;
    logic deferral_timeout;
    logic oversize_frame;
  } eefl_abort_t;

  // Interrupt source numbering
  typedef enum logic [3:0] {
    SRC_RX_ERR  = 4'h1,
    SRC_TX_ERR  = 4'h2,
    SRC_TX_DONE = 4'h4,
    SRC_LINK    = 4'h8
  } eefl_src_t;

endpackage : eefl_pkg

// file: logic/eefl_sticky_flag.sv
/*
  One sticky event flag: hardware set wins over clear.
  Assumes set and clear are synchronous to i_core_clk.
*/
`timescale 1ns/1ps
module eefl_sticky_flag (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_set,
  input  wire logic i_clr,
  // State
  output logic      o_flag
);
  import eefl_pkg::*;

  logic flag_d;
  logic flag_q;

  // Set beats a clear in the same cycle so no event is lost
  always_comb begin
    flag_d = flag_q;
    if (i_clr) begin
      flag_d = 1'b0;
    end
    if (i_set) begin
      flag_d = 1'b1;
    end
  end

  // Register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : eefl_sticky_flag
